// file: verilog/card_socket_general_control.sv
// card-detect, general control and global control registers of one socket
`timescale 1ns/1ns
module card_socket_general_control (
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic [7:0] addr_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o,
	input  wire logic       voltage_sense1_n_i,
	input  wire logic       voltage_sense2_n_i,
	input  wire logic       card_detect1_n_i,
	input  wire logic       card_detect2_n_i,
	input  wire logic       card_irq_n_i,
	input  wire logic       card_dma_req_i,
	input  wire logic       detect_irq_enable_i,
	input  wire logic       card_cycle_active_i,
	output logic            card_oe_o,
	output logic            card_dma_req_o,
	output logic            ring_indicate_out_n_o,
	output logic            compat_reset_o,
	output logic            host_irq_o,
	output logic            change_irq_o
);
	typedef struct packed {
		logic       detect_resume_en;
		logic       reset_regs_on_removal;
		logic       spare;
		logic       host_irq_level_sel;
		logic       flag_clear_sel;
		logic       change_irq_level_sel;
		logic       low_power_sel;
		logic [1:0] cd_prev;
		logic       change_flag;
		logic       ring_low;
		logic       compat_reset;
		logic [7:0] rdata;
	} ctrl_state_type;

	ctrl_state_type q;
	ctrl_state_type d;

	logic [socket_ctrl_pkg::SYNC_WIDTH-1:0] pins_raw;
	logic [socket_ctrl_pkg::SYNC_WIDTH-1:0] pins;
	logic [1:0]                             cd_now;
	logic                                   cd_change;
	logic                                   removal;
	logic                                   wr_detect;
	logic                                   wr_global;
	logic                                   wr_change;
	logic                                   rd_change;
	logic                                   soft_set;
	logic                                   flag_clr;

	irq_signal_if host_if ();
	irq_signal_if change_if ();

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	assign pins_raw = {card_irq_n_i, card_detect2_n_i, card_detect1_n_i,
		voltage_sense2_n_i, voltage_sense1_n_i};

	pin_sync u_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.pins_i  (pins_raw),
		.pins_o  (pins)
	);

	assign cd_now    = {pins[socket_ctrl_pkg::PIN_CD2], pins[socket_ctrl_pkg::PIN_CD1]};
	assign cd_change = (cd_now != q.cd_prev);
	assign removal   = (q.cd_prev == socket_ctrl_pkg::CD_PRESENT) && (cd_now != socket_ctrl_pkg::CD_PRESENT);
	assign wr_detect = wr_i && hit(addr_i, socket_ctrl_pkg::DETECT_CTRL_OFS);
	assign wr_global = wr_i && hit(addr_i, socket_ctrl_pkg::GLOBAL_CTRL_OFS);
	assign wr_change = wr_i && hit(addr_i, socket_ctrl_pkg::CHANGE_OFS);
	assign rd_change = rd_i && hit(addr_i, socket_ctrl_pkg::CHANGE_OFS);
	// soft detect is an action, never stored
	assign soft_set  = wr_detect && wdata_i[socket_ctrl_pkg::SOFT_DETECT_BIT] && detect_irq_enable_i;
	assign flag_clr  = q.flag_clear_sel
		? (wr_change && wdata_i[socket_ctrl_pkg::CHANGE_FLAG_BIT])
		: rd_change;

	always_comb begin
		d         = q;
		d.cd_prev = cd_now;
		if (wr_detect) begin
			// reserved bits have no storage behind them
			d.detect_resume_en      = wdata_i[socket_ctrl_pkg::RESUME_BIT];
			d.reset_regs_on_removal = wdata_i[socket_ctrl_pkg::REMOVAL_BIT];
		end
		if (wr_global) begin
			d.spare                = wdata_i[socket_ctrl_pkg::SPARE_BIT];
			d.host_irq_level_sel   = wdata_i[socket_ctrl_pkg::HOST_LVL_BIT];
			d.flag_clear_sel       = wdata_i[socket_ctrl_pkg::CLR_SEL_BIT];
			d.change_irq_level_sel = wdata_i[socket_ctrl_pkg::CHG_LVL_BIT];
			d.low_power_sel        = wdata_i[socket_ctrl_pkg::LOW_PWR_BIT];
		end
		// removal reset overrides a write in the same cycle
		d.compat_reset = removal && q.reset_regs_on_removal;
		if (d.compat_reset) begin
			d.detect_resume_en      = socket_ctrl_pkg::CTRL_RESET;
			d.reset_regs_on_removal = socket_ctrl_pkg::CTRL_RESET;
			d.spare                 = socket_ctrl_pkg::CTRL_RESET;
			d.host_irq_level_sel    = socket_ctrl_pkg::CTRL_RESET;
			d.flag_clear_sel        = socket_ctrl_pkg::CTRL_RESET;
			d.change_irq_level_sel  = socket_ctrl_pkg::CTRL_RESET;
			d.low_power_sel         = socket_ctrl_pkg::CTRL_RESET;
		end
		// a new event wins over a clear in the same cycle
		d.change_flag = cd_change || soft_set || (q.change_flag && !flag_clr);
		d.ring_low    = (q.detect_resume_en && cd_change) || (q.ring_low && d.change_flag);
		if (rd_i) begin
			if (hit(addr_i, socket_ctrl_pkg::DETECT_CTRL_OFS)) begin
				d.rdata = socket_ctrl_pkg::READ_ZERO;
				d.rdata[socket_ctrl_pkg::SENSE2_BIT]  = pins[socket_ctrl_pkg::PIN_VS2];
				d.rdata[socket_ctrl_pkg::SENSE1_BIT]  = pins[socket_ctrl_pkg::PIN_VS1];
				d.rdata[socket_ctrl_pkg::RESUME_BIT]  = q.detect_resume_en;
				d.rdata[socket_ctrl_pkg::REMOVAL_BIT] = q.reset_regs_on_removal;
			end else if (hit(addr_i, socket_ctrl_pkg::GLOBAL_CTRL_OFS)) begin
				d.rdata = socket_ctrl_pkg::READ_ZERO;
				d.rdata[socket_ctrl_pkg::SPARE_BIT]    = q.spare;
				d.rdata[socket_ctrl_pkg::HOST_LVL_BIT] = q.host_irq_level_sel;
				d.rdata[socket_ctrl_pkg::CLR_SEL_BIT]  = q.flag_clear_sel;
				d.rdata[socket_ctrl_pkg::CHG_LVL_BIT]  = q.change_irq_level_sel;
				d.rdata[socket_ctrl_pkg::LOW_PWR_BIT]  = q.low_power_sel;
			end else if (hit(addr_i, socket_ctrl_pkg::CHANGE_OFS)) begin
				d.rdata = socket_ctrl_pkg::READ_ZERO;
				d.rdata[socket_ctrl_pkg::CHANGE_FLAG_BIT] = q.change_flag;
			end else begin
				d.rdata = socket_ctrl_pkg::READ_ZERO;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			q         <= '0;
			q.cd_prev <= socket_ctrl_pkg::CD_ABSENT;
		end else if (ce_i) begin
			q <= d;
		end
	end

	// interrupts and dma requests are never gated by power-down
	assign host_if.flag        = !pins[socket_ctrl_pkg::PIN_IRQ];
	assign host_if.level_sel   = q.host_irq_level_sel;
	assign change_if.flag      = q.change_flag && detect_irq_enable_i;
	assign change_if.level_sel = q.change_irq_level_sel;

	host_irq_signal u_host_irq (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.port    (host_if.signaller)
	);

	host_irq_signal u_change_irq (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.port    (change_if.signaller)
	);

	assign rdata_o               = q.rdata;
	assign ring_indicate_out_n_o = !q.ring_low;
	assign compat_reset_o        = q.compat_reset;
	assign host_irq_o            = host_if.irq;
	assign change_irq_o          = change_if.irq;
	assign card_dma_req_o        = card_dma_req_i;
	// combinational so the outputs wake in the cycle the access begins
	assign card_oe_o             = !q.low_power_sel || card_cycle_active_i;

	property p_sense2;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && rd_i && hit(addr_i, socket_ctrl_pkg::DETECT_CTRL_OFS))
			|=> (rdata_o[socket_ctrl_pkg::SENSE2_BIT] == $past(pins[socket_ctrl_pkg::PIN_VS2]));
	endproperty
	a_sense2: assert property (p_sense2) else $error("sense2 status wrong");

	property p_sense1;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && rd_i && hit(addr_i, socket_ctrl_pkg::DETECT_CTRL_OFS))
			|=> (rdata_o[socket_ctrl_pkg::SENSE1_BIT] == $past(pins[socket_ctrl_pkg::PIN_VS1]));
	endproperty
	a_sense1: assert property (p_sense1) else $error("sense1 status wrong");

	property p_soft_set;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && soft_set) |=> q.change_flag;
	endproperty
	a_soft_set: assert property (p_soft_set) else $error("soft detect did not set flag");

	property p_soft_ignored;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && wr_detect && !detect_irq_enable_i && !q.change_flag && !cd_change)
			|=> !q.change_flag;
	endproperty
	a_soft_ignored: assert property (p_soft_ignored) else $error("soft detect acted while disabled");

	property p_detect_reserved;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && rd_i && hit(addr_i, socket_ctrl_pkg::DETECT_CTRL_OFS))
			|=> (rdata_o[socket_ctrl_pkg::SOFT_DETECT_BIT] == 1'b0) && (rdata_o[3:2] == 2'b00)
				&& (rdata_o[0] == 1'b0);
	endproperty
	a_detect_reserved: assert property (p_detect_reserved) else $error("detect reserved or soft bit nonzero");

	property p_resume;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && q.detect_resume_en && cd_change)
			|=> !ring_indicate_out_n_o ##1 (!ring_indicate_out_n_o || !q.change_flag);
	endproperty
	a_resume: assert property (p_resume) else $error("ring indicate not driven low");

	property p_ring_hold;
		@(posedge clock_i) disable iff (rst_i)
		(!ring_indicate_out_n_o && q.change_flag && !flag_clr) |=> !ring_indicate_out_n_o;
	endproperty
	a_ring_hold: assert property (p_ring_hold) else $error("ring indicate released early");

	property p_ring_release;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && q.ring_low && flag_clr && !cd_change && !soft_set) |=> ring_indicate_out_n_o;
	endproperty
	a_ring_release: assert property (p_ring_release) else $error("ring indicate held after flag clear");

	property p_removal_reset;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && removal && q.reset_regs_on_removal)
			|=> compat_reset_o && !q.low_power_sel && !q.reset_regs_on_removal;
	endproperty
	a_removal_reset: assert property (p_removal_reset) else $error("removal reset missed");

	property p_removal_keep;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && !q.reset_regs_on_removal) |=> !compat_reset_o;
	endproperty
	a_removal_keep: assert property (p_removal_keep) else $error("reset without removal config");

	property p_global_reserved;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && rd_i && hit(addr_i, socket_ctrl_pkg::GLOBAL_CTRL_OFS))
			|=> (rdata_o[7:5] == 3'b000) && (rdata_o[socket_ctrl_pkg::SPARE_BIT] == $past(q.spare));
	endproperty
	a_global_reserved: assert property (p_global_reserved) else $error("global control readback wrong");

	property p_spare_store;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && wr_global && !d.compat_reset) |=> (q.spare == $past(wdata_i[socket_ctrl_pkg::SPARE_BIT]));
	endproperty
	a_spare_store: assert property (p_spare_store) else $error("spare bit not stored");

	property p_read_clear;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && !q.flag_clear_sel && rd_change && !cd_change && !soft_set) |=> !q.change_flag;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read");

	property p_write_clear_only;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && q.flag_clear_sel && q.change_flag && !wr_change) |=> q.change_flag;
	endproperty
	a_write_clear_only: assert property (p_write_clear_only) else $error("flag lost without write one");

	property p_power_down;
		@(posedge clock_i) disable iff (rst_i)
		(q.low_power_sel && !card_cycle_active_i) |-> !card_oe_o;
	endproperty
	a_power_down: assert property (p_power_down) else $error("card outputs driven in power-down");

	property p_power_irq;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && q.low_power_sel && q.change_irq_level_sel && change_if.flag) |=> change_irq_o;
	endproperty
	a_power_irq: assert property (p_power_irq) else $error("interrupt blocked in power-down");

	property p_power_host;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && q.low_power_sel && q.host_irq_level_sel && host_if.flag) |=> host_irq_o;
	endproperty
	a_power_host: assert property (p_power_host) else $error("card interrupt blocked in power-down");

	property p_host_edge;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && !q.host_irq_level_sel && host_irq_o) |=> !host_irq_o;
	endproperty
	a_host_edge: assert property (p_host_edge) else $error("edge host interrupt longer than one clock");
endmodule : card_socket_general_control

// file: verilog/socket_ctrl_pkg.sv
// constants shared by the socket general control block
package socket_ctrl_pkg;
	// register offsets in the compatibility register set, and the all-zero read value
	localparam logic [7:0] CHANGE_OFS      = 8'h04;
	localparam logic [7:0] DETECT_CTRL_OFS = 8'h16;
	localparam logic [7:0] GLOBAL_CTRL_OFS = 8'h1e;
	localparam logic [7:0] READ_ZERO       = 8'h00;
	// card detect and general control fields
	localparam int SENSE2_BIT      = 7;
	localparam int SENSE1_BIT      = 6;
	localparam int SOFT_DETECT_BIT = 5;
	localparam int RESUME_BIT      = 4;
	localparam int REMOVAL_BIT     = 1;
	// global control fields
	localparam int SPARE_BIT    = 4;
	localparam int HOST_LVL_BIT = 3;
	localparam int CLR_SEL_BIT  = 2;
	localparam int CHG_LVL_BIT  = 1;
	localparam int LOW_PWR_BIT  = 0;
	// status-change register field
	localparam int CHANGE_FLAG_BIT = 0;
	// reset values and the card-present detect code
	localparam logic       CTRL_RESET   = 1'b0;
	localparam logic [1:0] CD_ABSENT    = 2'b11;
	localparam logic [1:0] CD_PRESENT   = 2'b00;
	// synchronised pin vector layout
	localparam int SYNC_WIDTH = 5;
	localparam int PIN_VS1    = 0;
	localparam int PIN_VS2    = 1;
	localparam int PIN_CD1    = 2;
	localparam int PIN_CD2    = 3;
	localparam int PIN_IRQ    = 4;
	localparam logic [SYNC_WIDTH-1:0] PINS_IDLE = 5'h1f;
endpackage : socket_ctrl_pkg

// file: verilog/irq_signal_if.sv
// flag, mode and interrupt line between the control block and a signaller
`timescale 1ns/1ns
interface irq_signal_if;
	logic flag;
	logic level_sel;
	logic irq;
	modport owner (
		output flag,
		output level_sel,
		input  irq
	);
	modport signaller (
		input  flag,
		input  level_sel,
		output irq
	);
endinterface : irq_signal_if

// file: verilog/pin_sync.sv
// two-stage synchroniser for the socket pins
`timescale 1ns/1ns
module pin_sync (
	input  wire logic                                 clock_i,
	input  wire logic                                 rst_i,
	input  wire logic                                 ce_i,
	input  wire logic [socket_ctrl_pkg::SYNC_WIDTH-1:0] pins_i,
	output logic      [socket_ctrl_pkg::SYNC_WIDTH-1:0] pins_o
);
	typedef struct packed {
		logic [socket_ctrl_pkg::SYNC_WIDTH-1:0] meta;
		logic [socket_ctrl_pkg::SYNC_WIDTH-1:0] safe;
	} sync_state_type;

	sync_state_type q;
	sync_state_type d;

	// first stage feeds only the second
	always_comb begin
		d      = q;
		d.meta = pins_i;
		d.safe = q.meta;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			q <= {socket_ctrl_pkg::PINS_IDLE, socket_ctrl_pkg::PINS_IDLE};
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign pins_o = q.safe;

	property p_two_stage;
		@(posedge clock_i) disable iff (rst_i)
		// the first stage must have left reset before its sample counts
		(!rst_i && ce_i) ##1 ce_i |=> (pins_o == $past(pins_i, 2));
	endproperty
	a_two_stage: assert property (p_two_stage) else $error("pin not delayed by two stages");
endmodule : pin_sync

// file: verilog/host_irq_signal.sv
// edge or level signalling of one host interrupt source
`timescale 1ns/1ns
module host_irq_signal (
	input  wire logic     clock_i,
	input  wire logic     rst_i,
	input  wire logic     ce_i,
	irq_signal_if.signaller port
);
	typedef struct packed {
		logic flag_prev;
		logic irq;
	} irq_state_type;

	irq_state_type q;
	irq_state_type d;

	always_comb begin
		d           = q;
		d.flag_prev = port.flag;
		// edge mode pulses once per new flag, level mode follows the flag
		d.irq = port.level_sel ? port.flag : (port.flag && !q.flag_prev);
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign port.irq = q.irq;

	property p_edge_pulse;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && q.irq && !port.level_sel) |=> (!q.irq || port.level_sel || !ce_i);
	endproperty
	a_edge_pulse: assert property (p_edge_pulse) else $error("edge interrupt longer than one clock");

	property p_level_hold;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && port.level_sel && port.flag) |=> q.irq;
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level interrupt not held with flag");
endmodule : host_irq_signal

// file: testbench/card_model.sv
// behavioural removable card seated in the socket
`timescale 1ns/1ns
module card_model (
	input  wire logic inserted_i,
	input  wire logic sense1_i,
	input  wire logic sense2_i,
	input  wire logic irq_i,
	input  wire logic dma_i,
	output logic      voltage_sense1_n_o,
	output logic      voltage_sense2_n_o,
	output logic      card_detect1_n_o,
	output logic      card_detect2_n_o,
	output logic      card_irq_n_o,
	output logic      card_dma_req_o
);
	// socket pull-ups hold every active-low line high while no card is seated
	assign card_detect1_n_o   = ~inserted_i;
	assign card_detect2_n_o   = ~inserted_i;
	assign voltage_sense1_n_o = inserted_i ? sense1_i : 1'b1;
	assign voltage_sense2_n_o = inserted_i ? sense2_i : 1'b1;
	// an empty socket cannot interrupt or request dma
	assign card_irq_n_o       = ~(inserted_i & irq_i);
	assign card_dma_req_o     = inserted_i & dma_i;
endmodule : card_model

// file: testbench/card_socket_general_control_tb.sv
// self-checking bench for the socket general control registers
`timescale 1ns/1ns
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module card_socket_general_control_tb;
	logic       clock_i;
	logic       rst_i;
	logic       ce_i;
	logic [7:0] addr_i;
	logic       wr_i;
	logic       rd_i;
	logic [7:0] wdata_i;
	logic [7:0] rdata_o;
	logic       vs1_n, vs2_n, cd1_n, cd2_n, irq_n, dma_c;
	logic       enable_i, cycle_i, card_oe, dma_o, ring_n, compat_rst, host_irq, chg_irq;
	logic       inserted, sense1, sense2, card_irq, card_dma;
	int         failures, n_tests, n_chg, n_host, n_compat, base;

	card_socket_general_control DUT (
		.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
		.wdata_i(wdata_i), .rdata_o(rdata_o), .voltage_sense1_n_i(vs1_n), .voltage_sense2_n_i(vs2_n),
		.card_detect1_n_i(cd1_n), .card_detect2_n_i(cd2_n), .card_irq_n_i(irq_n), .card_dma_req_i(dma_c),
		.detect_irq_enable_i(enable_i), .card_cycle_active_i(cycle_i), .card_oe_o(card_oe),
		.card_dma_req_o(dma_o), .ring_indicate_out_n_o(ring_n), .compat_reset_o(compat_rst),
		.host_irq_o(host_irq), .change_irq_o(chg_irq));

	card_model card (
		.inserted_i(inserted), .sense1_i(sense1), .sense2_i(sense2), .irq_i(card_irq), .dma_i(card_dma),
		.voltage_sense1_n_o(vs1_n), .voltage_sense2_n_o(vs2_n), .card_detect1_n_o(cd1_n),
		.card_detect2_n_o(cd2_n), .card_irq_n_o(irq_n), .card_dma_req_o(dma_c));

	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	// pulse counters sample registered outputs before the edge updates them
	always @(posedge clock_i) begin
		if (!rst_i) begin
			n_chg    <= n_chg + int'(chg_irq);
			n_host   <= n_host + int'(host_irq);
			n_compat <= n_compat + int'(compat_rst);
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i    <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i   <= 1'b0;
		@(negedge clock_i);
		`CHK(rdata_o, e)
	endtask : rd_chk

	// ends mid-cycle so registered outputs have settled
	task automatic wait_n(input int n);
		repeat (n) @(posedge clock_i);
		@(negedge clock_i);
	endtask : wait_n

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		#100us;
		failures++;
		complete_run();
	end

	initial begin
		rst_i = 1'b1; ce_i = 1'b1; addr_i = 8'h00; wr_i = 1'b0; rd_i = 1'b0; wdata_i = 8'h00;
		enable_i = 1'b0; cycle_i = 1'b0; inserted = 1'b0; sense1 = 1'b1; sense2 = 1'b1;
		card_irq = 1'b0; card_dma = 1'b0;
		failures = 0; n_tests = 0; n_chg = 0; n_host = 0; n_compat = 0; base = 0;
		repeat (5) @(posedge clock_i);
		rst_i <= 1'b0;
		wait_n(5);
		rd_chk(8'h16, 8'hc0);
		rd_chk(8'h1e, 8'h00);
		rd_chk(8'h04, 8'h00);
		rd_chk(8'h20, 8'h00);
		`CHK(card_oe, 1'b1)
		// writes are dropped while the clock enable is low
		@(posedge clock_i) ce_i <= 1'b0;
		wr(8'h1e, 8'h08);
		ce_i <= 1'b1;
		rd_chk(8'h1e, 8'h00);
		wr(8'h1e, 8'hff);
		rd_chk(8'h1e, 8'h1f);
		base = n_chg;
		wr(8'h16, 8'hff);
		rd_chk(8'h16, 8'hd2);
		rd_chk(8'h04, 8'h00);
		`CHK(n_chg - base, 0)
		wr(8'h16, 8'h00);
		wr(8'h1e, 8'h00);
		// soft detect in edge mode with clear on read
		@(posedge clock_i) enable_i <= 1'b1;
		base = n_chg;
		wr(8'h16, 8'h20);
		wait_n(6);
		`CHK(n_chg - base, 1)
		rd_chk(8'h04, 8'h01);
		rd_chk(8'h04, 8'h00);
		// level mode, flags cleared only by writing one
		wr(8'h1e, 8'h06);
		wr(8'h16, 8'h20);
		wait_n(4);
		`CHK(chg_irq, 1'b1)
		rd_chk(8'h04, 8'h01);
		rd_chk(8'h04, 8'h01);
		wr(8'h04, 8'h01);
		wait_n(4);
		`CHK(chg_irq, 1'b0)
		rd_chk(8'h04, 8'h00);
		// insertion with resume enabled pulls ring low until the flag clears
		wr(8'h16, 8'h10);
		@(posedge clock_i) inserted <= 1'b1;
		sense1 <= 1'b0;
		wait_n(8);
		`CHK(ring_n, 1'b0)
		rd_chk(8'h16, 8'h90);
		wait_n(10);
		`CHK(ring_n, 1'b0)
		wr(8'h04, 8'h01);
		wait_n(3);
		`CHK(ring_n, 1'b1)
		// power-down keeps outputs off outside card cycles
		wr(8'h1e, 8'h01);
		wait_n(1);
		`CHK(card_oe, 1'b0)
		@(posedge clock_i) cycle_i <= 1'b1;
		@(negedge clock_i);
		`CHK(card_oe, 1'b1)
		@(posedge clock_i) cycle_i <= 1'b0;
		card_dma <= 1'b1;
		@(negedge clock_i);
		`CHK(card_oe, 1'b0)
		`CHK(dma_o, 1'b1)
		@(posedge clock_i) card_dma <= 1'b0;
		base = n_host;
		card_irq <= 1'b1;
		wait_n(8);
		`CHK(n_host - base, 1)
		`CHK(dma_o, 1'b0)
		wr(8'h1e, 8'h09);
		wait_n(3);
		`CHK(host_irq, 1'b1)
		@(posedge clock_i) card_irq <= 1'b0;
		wait_n(6);
		`CHK(host_irq, 1'b0)
		// removal with the reset option off keeps contents
		wr(8'h16, 8'h00);
		wr(8'h1e, 8'h10);
		base = n_compat;
		@(posedge clock_i) inserted <= 1'b0;
		wait_n(8);
		`CHK(ring_n, 1'b1)
		`CHK(n_compat - base, 0)
		rd_chk(8'h1e, 8'h10);
		// removal with the reset option on clears both registers
		@(posedge clock_i) inserted <= 1'b1;
		wait_n(8);
		wr(8'h16, 8'h12);
		wr(8'h1e, 8'h1f);
		base = n_compat;
		@(posedge clock_i) inserted <= 1'b0;
		wait_n(8);
		`CHK(n_compat - base, 1)
		rd_chk(8'h1e, 8'h00);
		rd_chk(8'h16, 8'hc0);
		complete_run();
	end
endmodule : card_socket_general_control_tb
